// *** hw/asdm_bank.v ***
// Status, error, counter and data memory save word bank
//
// Summary of operation
// R1: Slot word bits 0..3 are one-hot, bit n set in slot n+1.
// R2: Save status bit 11 sets when the restored flash image is invalid.
// R3: Any save to flash clears the image-invalid indication, unless a bad restore is reported in the cycle the save ends.
// R4: Save status bit 12 sets when a start is attempted while the key word is not the save key.
// R5: Save status bit 13 sets when a save to flash fails.
// R6: Save status bit 14 stays high while a save is in progress.
// R7: Software writes the key first, then sets start bit 15.
// R8: A save runs only in program mode.
// R9: A save is accepted only if the key word equals A5A5 at start.
// R10: The key word clears to zero once a save completes without failure; a failed save leaves it.
// R11: Module error bit 8 sets on a coordinator watchdog timeout.
// R12: Module error bit 9 sets on a coordinator fatal error.
// R13: Memory error bit 13 sets on bad analog calibration data in flash.
// R14: Counter 1 value is a signed 32-bit value over two words.
// R15: With no valid image at power-up, restore is skipped and words zeroed.
// R16: A save ends by clearing busy and start; a rejected one leaves flash alone.
// R17: Slot, error and counter words ignore software writes.
`timescale 1ns/1ns
`default_nettype none
`include "asdm_map.vh"
module asdm_bank #(
  parameter AW = 10
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [AW-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Module status inputs
  input wire [1:0] slot_index,
  input wire program_mode,
  input wire coord_wdt_error,
  input wire coord_fatal_error,
  input wire cal_data_error,
  input wire signed [31:0] counter1_value,
  // Power-up restore of the data memory area
  input wire restore_done,
  input wire restore_image_bad,
  output wire restore_zero_fill,
  // Flash save engine
  output reg save_req,
  input wire save_done,
  input wire save_fail,
  // Interrupt
  output wire irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SAVE = 1'b1;

  reg state_r;
  reg invalid_r;
  reg badkey_r;
  reg fail_r;
  reg start_r;
  reg [15:0] key_r;
  reg wdt_r;
  reg fatal_r;
  reg cal_r;
  reg [`ASDM_IRQ_W-1:0] irq_stat_r;
  reg [`ASDM_IRQ_W-1:0] irq_mask_r;
  reg [`ASDM_IRQ_W-1:0] irq_ev;

  function hit;
    input [AW-1:0] a;
    input [AW-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  wire sel_slot = hit(reg_addr, `ASDM_OFF_SLOT);
  wire sel_merr = hit(reg_addr, `ASDM_OFF_MERR);
  wire sel_memerr = hit(reg_addr, `ASDM_OFF_MEMERR);
  wire sel_save = hit(reg_addr, `ASDM_OFF_SAVE);
  wire sel_key = hit(reg_addr, `ASDM_OFF_KEY);
  wire sel_cnt_lo = hit(reg_addr, `ASDM_OFF_CNT_LO);
  wire sel_cnt_hi = hit(reg_addr, `ASDM_OFF_CNT_HI);
  wire sel_istat = hit(reg_addr, `ASDM_OFF_IRQ_STAT);
  wire sel_imask = hit(reg_addr, `ASDM_OFF_IRQ_MASK);

  // Read-only words get no write enable, so a write cannot reach them
  wire wr_save = reg_wr && sel_save;
  wire wr_key = reg_wr && sel_key;
  wire wr_imask = reg_wr && sel_imask;
  wire rd_istat = reg_rd && sel_istat;

  // -----------------------------------------------------------------
  // Save request qualification
  // -----------------------------------------------------------------
  wire busy = (state_r == ST_SAVE);
  // A start written while a save runs is dropped, so requests never queue
  wire start_req = wr_save && reg_wdata[`ASDM_BIT_START] && !busy;
  wire key_ok = (key_r == `ASDM_SAVE_KEY);
  wire accept = start_req && key_ok && program_mode; // R8 R9
  wire reject = start_req && !accept;
  wire finish = busy && (save_done || save_fail);
  // Fail wins when the engine reports both at once
  wire finish_ok = finish && save_done && !save_fail;
  wire finish_bad = finish && save_fail;
  wire restore_bad = restore_done && restore_image_bad;

  // -----------------------------------------------------------------
  // Save sequence
  // -----------------------------------------------------------------
  reg state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (finish) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      save_req <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // One pulse per accepted request; a rejected one never reaches flash
      save_req <= accept; // R16
    end
  end

  // -----------------------------------------------------------------
  // Start bit: high from an accepted request until the save ends
  // -----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      start_r <= 1'b0;
    end else if (accept) begin
      start_r <= 1'b1;
    end else if (finish) begin
      start_r <= 1'b0; // R16
    end
  end

  // -----------------------------------------------------------------
  // Key word
  // -----------------------------------------------------------------
  // The key cannot change under a running save, so the checked value holds
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      key_r <= `ASDM_ZERO16;
    end else if (finish_ok) begin
      key_r <= `ASDM_ZERO16; // R10
    end else if (wr_key && !busy) begin
      key_r <= reg_wdata;
    end
  end

  // -----------------------------------------------------------------
  // Save status flags
  // -----------------------------------------------------------------
  // Rewritten on every start attempt made while no save runs, so a good key clears it again
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      badkey_r <= 1'b0;
    end else if (start_req) begin
      badkey_r <= !key_ok; // R4
    end
  end

  // Cleared by the next accepted request, so it tells of the last save only
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fail_r <= 1'b0;
    end else if (finish) begin
      fail_r <= save_fail; // R5
    end else if (accept) begin
      fail_r <= 1'b0;
    end
  end

  // A restore report in the cycle of a save end wins over the clear
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      invalid_r <= 1'b0;
    end else if (restore_bad) begin
      invalid_r <= 1'b1; // R2
    end else if (finish) begin
      invalid_r <= 1'b0; // R3
    end
  end

  // -----------------------------------------------------------------
  // Power-up restore
  // -----------------------------------------------------------------
  // With no valid image the restore is skipped and the words are zeroed
  assign restore_zero_fill = restore_bad; // R15

  // -----------------------------------------------------------------
  // Error flags follow their sources one cycle late
  // -----------------------------------------------------------------
  // Mirrors only: the coordinator owns the clearing, software cannot clear
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wdt_r <= 1'b0;
    end else begin
      wdt_r <= coord_wdt_error; // R11
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fatal_r <= 1'b0;
    end else begin
      fatal_r <= coord_fatal_error; // R12
    end
  end

  // Meaningful on the analog variant only; other variants tie the input low
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_r <= 1'b0;
    end else begin
      cal_r <= cal_data_error; // R13
    end
  end

  // -----------------------------------------------------------------
  // Interrupt events
  // -----------------------------------------------------------------
  // Coordinator errors raise an event on their rising edge only
  wire wdt_rise = coord_wdt_error && !wdt_r;
  wire fatal_rise = coord_fatal_error && !fatal_r;

  always @* begin
    irq_ev = {`ASDM_IRQ_W{1'b0}};
    irq_ev[`ASDM_IRQ_DONE] = finish_ok;
    irq_ev[`ASDM_IRQ_FAIL] = finish_bad;
    irq_ev[`ASDM_IRQ_BADKEY] = reject;
    irq_ev[`ASDM_IRQ_CERR] = wdt_rise || fatal_rise;
  end

  // -----------------------------------------------------------------
  // Interrupt status: set wins over read clear
  // -----------------------------------------------------------------
  wire [`ASDM_IRQ_W-1:0] irq_stat_nxt;
  genvar g;
  generate
    for (g = 0; g < `ASDM_IRQ_W; g = g + 1) begin : g_irq
      // An event in the clearing read's cycle survives the clear
      assign irq_stat_nxt[g] = irq_ev[g] || (irq_stat_r[g] && !rd_istat);
    end
  endgenerate

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_stat_r <= {`ASDM_IRQ_W{1'b0}};
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Interrupt mask
  // -----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask_r <= {`ASDM_IRQ_W{1'b0}};
    end else if (wr_imask) begin
      irq_mask_r <= reg_wdata[`ASDM_IRQ_W-1:0];
    end
  end

  // Level output: high while any unmasked status bit is set
  assign irq = |(irq_stat_r & irq_mask_r);

  // -----------------------------------------------------------------
  // Slot indicators
  // -----------------------------------------------------------------
  wire [`ASDM_SLOT_BITS-1:0] slot_onehot;
  generate
    for (g = 0; g < `ASDM_SLOT_BITS; g = g + 1) begin : g_slot
      // Exactly one index matches, so the word is always one-hot
      assign slot_onehot[g] = (slot_index == g); // R1
    end
  endgenerate

  // -----------------------------------------------------------------
  // Word images
  // -----------------------------------------------------------------
  reg [15:0] save_word;
  reg [15:0] merr_word;
  reg [15:0] memerr_word;
  always @* begin
    save_word = `ASDM_ZERO16;
    save_word[`ASDM_BIT_INVALID] = invalid_r;
    save_word[`ASDM_BIT_BADKEY] = badkey_r;
    save_word[`ASDM_BIT_FAIL] = fail_r;
    save_word[`ASDM_BIT_BUSY] = busy; // R6
    save_word[`ASDM_BIT_START] = start_r;
    merr_word = `ASDM_ZERO16;
    merr_word[`ASDM_BIT_WDT] = wdt_r;
    merr_word[`ASDM_BIT_FATAL] = fatal_r;
    memerr_word = `ASDM_ZERO16;
    memerr_word[`ASDM_BIT_CAL] = cal_r;
  end

  // -----------------------------------------------------------------
  // Read data, one cycle after the strobe; unmapped reads give zero
  // -----------------------------------------------------------------
  // The counter words are read live with no latch, so software pairing the
  // two halves must allow for a carry between the two reads
  reg [15:0] rd_nxt;
  always @* begin
    rd_nxt = `ASDM_ZERO16;
    if (sel_slot) begin
      rd_nxt[`ASDM_SLOT_BITS-1:0] = slot_onehot; // R1 R17
    end else if (sel_merr) begin
      rd_nxt = merr_word;
    end else if (sel_memerr) begin
      rd_nxt = memerr_word;
    end else if (sel_save) begin
      rd_nxt = save_word;
    end else if (sel_key) begin
      rd_nxt = key_r;
    end else if (sel_cnt_lo) begin
      rd_nxt = counter1_value[15:0]; // R14
    end else if (sel_cnt_hi) begin
      rd_nxt = counter1_value[31:16]; // R14
    end else if (sel_istat) begin
      rd_nxt[`ASDM_IRQ_W-1:0] = irq_stat_r;
    end else if (sel_imask) begin
      rd_nxt[`ASDM_IRQ_W-1:0] = irq_mask_r;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `ASDM_ZERO16;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= `ASDM_ZERO16;
    end
  end

endmodule // asdm_bank
`default_nettype wire

// *** pkg/asdm_map.vh ***
// Register offsets, field positions and constants of the status and save word bank
`ifndef ASDM_MAP_VH
`define ASDM_MAP_VH
`define ASDM_OFF_SLOT 10'h010e
`define ASDM_OFF_MERR 10'h0192
`define ASDM_OFF_MEMERR 10'h0193
`define ASDM_OFF_SAVE 10'h02ef
`define ASDM_OFF_KEY 10'h02f0
`define ASDM_OFF_CNT_LO 10'h0352
`define ASDM_OFF_CNT_HI 10'h0353
`define ASDM_OFF_IRQ_STAT 10'h03f0
`define ASDM_OFF_IRQ_MASK 10'h03f1
`define ASDM_SLOT_BITS 4
`define ASDM_BIT_WDT 8
`define ASDM_BIT_FATAL 9
`define ASDM_BIT_CAL 13
`define ASDM_BIT_INVALID 11
`define ASDM_BIT_BADKEY 12
`define ASDM_BIT_FAIL 13
`define ASDM_BIT_BUSY 14
`define ASDM_BIT_START 15
`define ASDM_SAVE_KEY 16'ha5a5
`define ASDM_ZERO16 16'h0000
`define ASDM_IRQ_W 4
`define ASDM_IRQ_DONE 0
`define ASDM_IRQ_FAIL 1
`define ASDM_IRQ_BADKEY 2
`define ASDM_IRQ_CERR 3
`endif

// *** verif/asdm_properties.sv ***
// Port checker of the status and save bank
`timescale 1ns/1ns
`default_nettype none
`include "asdm_map.vh"
module asdm_chk (
  // Watched ports
  input wire clk,
  input wire reset,
  input wire [9:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [1:0] slot_index,
  input wire program_mode,
  input wire coord_wdt_error,
  input wire signed [31:0] counter1_value,
  input wire restore_done,
  input wire restore_image_bad,
  input wire restore_zero_fill,
  input wire save_req,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  quiet_rd_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray data");
  zero_fill_a: assert property (restore_zero_fill == (restore_done && restore_image_bad))
    else $error("zero fill");
  req_pulse_a: assert property (save_req |=> !save_req) else $error("long request");
  req_mode_a: assert property (save_req |-> $past(program_mode)) else $error("save off mode");
  slot_hot_a: assert property (reg_rd && reg_addr == 10'h010e
    |=> reg_rdata == 16'h0001 << $past(slot_index)) else $error("slot");
  cnt_lo_a: assert property (reg_rd && reg_addr == 10'h0352
    |=> reg_rdata == $past(counter1_value[15:0])) else $error("count");
  wdt_flag_a: assert property (reg_rd && reg_addr == 10'h0192 && $stable(coord_wdt_error)
    |=> reg_rdata[8] == $past(coord_wdt_error)) else $error("watchdog");
  busy_seen_a: assert property (save_req ##1 reg_rd && reg_addr == 10'h02ef |=> reg_rdata[14])
    else $error("busy");
  cover property (save_req);
  cover property (irq);
  cover property (restore_zero_fill);
endmodule // asdm_chk
bind asdm_bank asdm_chk u_chk (.*);
`default_nettype wire

// *** verif/asdm_bank_test.sv ***
// Self-checking bench of the status and save bank
`timescale 1ns/1ns
`default_nettype none
module asdm_bank_test;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, program_mode = 1, coord_wdt_error = 0;
  logic coord_fatal_error = 0, cal_data_error = 0, restore_done = 0, restore_image_bad = 0;
  logic save_done = 0, save_fail = 0, restore_zero_fill, save_req, irq;
  logic [9:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [1:0] slot_index = 0;
  logic signed [31:0] counter1_value = 0;
  int bad_count = 0, num_checks = 0, i;
  always #20 clk = ~clk;
  asdm_bank u_dut (.*);
  task chk(input string nm, input [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task chk_bit(input string nm, input got, exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s exp %b got %b", nm, exp, got);
      bad_count++;
    end
  endtask
  // Write when w is high, else read and compare with d
  task acc(input w, input [9:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
    if (!w) chk($sformatf("word %h", a), reg_rdata, d);
  endtask
  task sv(input f, input [15:0] busy);
    acc(1, 10'h02ef, 16'h8000);
    for (i = 0; i < 8 && !save_req; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 8) begin
      bad_count++;
      results;
    end
    acc(0, 10'h02ef, busy);
    @(posedge clk);
    save_done <= !f;
    save_fail <= f;
    @(posedge clk);
    save_done <= 0;
    save_fail <= 0;
  endtask
  task t_status;
    coord_wdt_error <= 1;
    coord_fatal_error <= 1;
    cal_data_error <= 1;
    counter1_value <= 32'h8000_0000;
    for (int s = 0; s < 4; s++) begin
      slot_index <= s[1:0];
      acc(0, 10'h010e, 16'h0001 << s);
    end
    acc(1, 10'h0192, 16'h0000);
    acc(0, 10'h0192, 16'h0300);
    acc(0, 10'h0193, 16'h2000);
    acc(0, 10'h0352, 16'h0000);
    acc(0, 10'h0353, 16'h8000);
    acc(0, 10'h03ff, 16'h0000);
    acc(0, 10'h03f0, 16'h0008);
    $display("status done");
  endtask
  task t_save;
    @(posedge clk);
    restore_image_bad <= 1;
    restore_done <= 1;
    #1;
    chk_bit("zero fill", restore_zero_fill, 1'b1);
    @(posedge clk);
    restore_done <= 0;
    acc(0, 10'h02ef, 16'h0800);
    acc(1, 10'h02f0, 16'h1234);
    acc(1, 10'h02ef, 16'h8000);
    acc(0, 10'h02ef, 16'h1800);
    acc(0, 10'h03f0, 16'h0004);
    acc(1, 10'h03f1, 16'h0001);
    acc(0, 10'h03f1, 16'h0001);
    acc(1, 10'h02f0, 16'ha5a5);
    sv(1, 16'hc800);
    acc(0, 10'h02ef, 16'h2000);
    chk_bit("irq", irq, 1'b0);
    sv(0, 16'hc000);
    acc(0, 10'h02ef, 16'h0000);
    acc(0, 10'h02f0, 16'h0000);
    chk_bit("irq", irq, 1'b1);
    acc(0, 10'h03f0, 16'h0003);
    chk_bit("irq", irq, 1'b0);
    program_mode <= 0;
    acc(1, 10'h02f0, 16'ha5a5);
    acc(1, 10'h02ef, 16'h8000);
    acc(0, 10'h02ef, 16'h0000);
    $display("save done");
  endtask
  task results;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    t_status;
    t_save;
    results;
  end
endmodule // asdm_bank_test
`default_nettype wire
